// ===== rtl/sfp_cfg.svh
// offsets, field positions, reset values and timing for the forwarding policy
`ifndef SFP_CFG_SVH
`define SFP_CFG_SVH

// register indexes, byte address is four times the index
`define SFP_IDX_GCTL3 10'd5
`define SFP_IDX_PORT5 10'd12
`define SFP_IDX_MLD 10'd164
`define SFP_IDX_TD0 10'd180
`define SFP_IDX_TD1 10'd181
`define SFP_IDX_TD2 10'd182
`define SFP_IDX_TCMD 10'd183
`define SFP_IDX_STAT 10'd184
`define SFP_IDX_DROPS 10'd185
`define SFP_PORT_PAGE 5'd6

// control bit positions
`define SFP_B_AND_MIRROR 0
`define SFP_B_IGMP 6
`define SFP_B_VLAN 7
`define SFP_B_TAIL 1
`define SFP_B_MLD 2
`define SFP_B_MLD_EXT 3
`define SFP_B_RX_SNIFF 0
`define SFP_B_TX_SNIFF 1
`define SFP_B_SNIFFER 2
`define SFP_B_MIR_BAD 3
`define SFP_B_SPEED10 4
`define SFP_B_GIG 5
`define SFP_B_DISC_NPVID 5
`define SFP_B_IN_FILTER 6

// table entry fields
`define SFP_VT_FID 6:0
`define SFP_VT_MEMB 11:7
`define SFP_VT_VALID 12
`define SFP_VT_VID 24:13
`define SFP_ST_MAC 47:0
`define SFP_ST_PORTS 52:48
`define SFP_ST_VALID 53
`define SFP_ST_USEG 54
`define SFP_ST_FID 61:55
`define SFP_DT_MAC 47:0
`define SFP_DT_FID 54:48
`define SFP_DT_PORT 58:56
`define SFP_DT_VALID 59
`define SFP_DT_STAMP 63:60

// reset values
`define SFP_RST_GCTL3 8'h00
`define SFP_RST_PCTL1 8'h00
`define SFP_RST_PVID 12'h001

// protocol values
`define SFP_IP_V4 4'h4
`define SFP_PROTO_IGMP 8'h02
`define SFP_NH_HBH 8'h00
`define SFP_NH_ICMP 8'h01
`define SFP_NH_ICMP6 8'h3A

// rate refill period
`define SFP_CLK_NS 50
`define SFP_TICK_NS 1000000
`define SFP_TICK_CYC (`SFP_TICK_NS / `SFP_CLK_NS)
`define SFP_HOST 3'd4

`endif

// ===== rtl/sfp_pkg.sv
// types shared by the forwarding policy block
package sfp_pkg;
	typedef logic [24:0] sfp_vlan_t;
	typedef logic [61:0] sfp_static_t;
	typedef logic [63:0] sfp_dyn_t;
	typedef logic [4:0] sfp_pmask_t;
	typedef logic [6:0] sfp_rate_t;
endpackage

// ===== rtl/sfp_top.sv
// forwarding policy: snooping, mirroring, VLAN and MAC look-up, rate limiting
//
// Chosen here: register access over AXI4-Lite and the register offsets.
`include "sfp_cfg.svh"

module sfp_top import sfp_pkg::*; #(
	parameter int ST_N = 4,
	parameter int DT_N = 8,
	parameter int TICK_CYC = `SFP_TICK_CYC,
	parameter int BKT_MAX = 65536
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite register slave
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// frame descriptor from the parser
	input wire logic fd_valid,
	input wire logic [2:0] fd_port,
	input wire logic fd_err,
	input wire logic [15:0] fd_len,
	input wire logic [47:0] fd_da,
	input wire logic [47:0] fd_sa,
	input wire logic fd_tagged,
	input wire logic [11:0] fd_vid,
	input wire logic fd_is_ip,
	input wire logic [3:0] fd_ip_ver,
	input wire logic [7:0] fd_ip_proto,
	input wire logic fd_ip6_mcast,
	input wire logic [7:0] fd_hop_limit,
	input wire logic [7:0] fd_next_hdr,
	input wire logic [7:0] fd_hbh_next,
	input wire logic [7:0] fd_tail_tag,
	// forwarding decision
	output logic dec_valid,
	output logic [4:0] dec_ports,
	output logic dec_drop,
	output logic dec_trap,
	output logic [7:0] dec_tail_tag
);
	localparam int TW = $clog2(TICK_CYC + 1);

	logic [7:0] gctl3;
	logic tail_on;
	logic mld_on;
	logic mld_ext;
	logic [7:0] pctl1 [5];
	logic [1:0] pctl2 [5];
	logic [11:0] pvid [5];
	sfp_rate_t rate_in [5];
	sfp_rate_t rate_eg [5];
	logic [31:0] td [3];
	sfp_vlan_t vtab [128];
	sfp_static_t stab [ST_N];
	sfp_dyn_t dtab [DT_N];
	logic [$clog2(DT_N)-1:0] dt_ptr;
	logic [3:0] age;
	logic [15:0] learn_cnt;
	logic [15:0] drop_cnt;
	logic [TW-1:0] tick_cnt;
	logic tick;
	logic [23:0] bkt_in [5];
	logic [23:0] bkt_eg [5];

	// bus handshakes: one write and one read at a time
	logic wr_go;
	logic rd_go;
	logic [9:0] wr_idx;
	logic [9:0] rd_idx;
	assign wr_go = s_axi_awready & s_axi_awvalid & s_axi_wvalid;
	assign rd_go = s_axi_arready & s_axi_arvalid;
	assign wr_idx = s_axi_awaddr[11:2];
	assign rd_idx = s_axi_araddr[11:2];

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'b00;
		end else begin
			s_axi_awready <= ~s_axi_awready & s_axi_awvalid & s_axi_wvalid
				& ~s_axi_bvalid;
			s_axi_wready <= ~s_axi_awready & s_axi_awvalid & s_axi_wvalid
				& ~s_axi_bvalid;
			if (wr_go) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_map(wr_idx) ? 2'b00 : 2'b10;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	function automatic logic wr_map(input logic [9:0] i);
		wr_map = (i == `SFP_IDX_GCTL3) || (i == `SFP_IDX_PORT5)
			|| (i == `SFP_IDX_MLD) || (i >= `SFP_IDX_TD0
			&& i <= `SFP_IDX_DROPS) || (i[9:5] == `SFP_PORT_PAGE
			&& i[4:2] < 3'd5);
	endfunction

	// register writes; wstrb lane 0 guards the global control registers, port registers and data words ignore it
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			gctl3 <= `SFP_RST_GCTL3;
			tail_on <= 1'b0;
			mld_on <= 1'b0;
			mld_ext <= 1'b0;
			for (int p = 0; p < 5; p++) begin
				pctl1[p] <= `SFP_RST_PCTL1;
				pctl2[p] <= 2'b00;
				pvid[p] <= `SFP_RST_PVID;
				rate_in[p] <= 7'h00;
				rate_eg[p] <= 7'h00;
			end
			for (int k = 0; k < 3; k++) begin
				td[k] <= 32'h00000000;
			end
		end else if (wr_go) begin
			if (wr_idx == `SFP_IDX_GCTL3 && s_axi_wstrb[0])
				gctl3 <= s_axi_wdata[7:0];
			if (wr_idx == `SFP_IDX_PORT5 && s_axi_wstrb[0])
				tail_on <= s_axi_wdata[`SFP_B_TAIL];
			if (wr_idx == `SFP_IDX_MLD && s_axi_wstrb[0]) begin
				mld_on <= s_axi_wdata[`SFP_B_MLD];
				mld_ext <= s_axi_wdata[`SFP_B_MLD_EXT];
			end
			for (int k = 0; k < 3; k++) begin
				if (wr_idx == `SFP_IDX_TD0 + 10'(k))
					td[k] <= s_axi_wdata;
			end
			if (wr_idx[9:5] == `SFP_PORT_PAGE && wr_idx[4:2] < 3'd5) begin
				case (wr_idx[1:0])
					2'd0: pctl1[wr_idx[4:2]] <= s_axi_wdata[7:0];
					2'd1: pctl2[wr_idx[4:2]] <= s_axi_wdata[6:5];
					2'd2: pvid[wr_idx[4:2]] <= s_axi_wdata[11:0];
					default: begin
						rate_in[wr_idx[4:2]] <= s_axi_wdata[6:0];
						rate_eg[wr_idx[4:2]] <= s_axi_wdata[14:8];
					end
				endcase
			end
		end
	end

	// indirect table writes through the first two data words
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int i = 0; i < 128; i++) vtab[i] <= '0;
			for (int i = 0; i < ST_N; i++) stab[i] <= '0;
		end else if (wr_go && wr_idx == `SFP_IDX_TCMD) begin
			if (s_axi_wdata[8])
				stab[s_axi_wdata[6:0] % ST_N] <= {td[1][29:0], td[0]};
			else
				vtab[s_axi_wdata[6:0]] <= td[0][24:0];
		end
	end

	// read side
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= 2'b00;
		end else begin
			s_axi_arready <= ~s_axi_arready & s_axi_arvalid & ~s_axi_rvalid;
			if (rd_go) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= wr_map(rd_idx) ? 2'b00 : 2'b10;
				s_axi_rdata <= rd_mux(rd_idx);
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	function automatic logic [31:0] rd_mux(input logic [9:0] i);
		logic [2:0] p;
		p = i[4:2];
		rd_mux = 32'h00000000;
		if (i == `SFP_IDX_GCTL3) rd_mux = {24'h000000, gctl3};
		if (i == `SFP_IDX_PORT5) rd_mux = {30'h0, tail_on, 1'b0};
		if (i == `SFP_IDX_MLD) rd_mux = {28'h0, mld_ext, mld_on, 2'b00};
		if (i == `SFP_IDX_TD0) rd_mux = td[0];
		if (i == `SFP_IDX_TD1) rd_mux = td[1];
		if (i == `SFP_IDX_TD2) rd_mux = td[2];
		if (i == `SFP_IDX_STAT) rd_mux = {16'h0000, learn_cnt};
		if (i == `SFP_IDX_DROPS) rd_mux = {16'h0000, drop_cnt};
		if (i[9:5] == `SFP_PORT_PAGE && p < 3'd5) begin
			case (i[1:0])
				2'd0: rd_mux = {24'h000000, pctl1[p]};
				2'd1: rd_mux = {25'h0, pctl2[p], 5'h00};
				2'd2: rd_mux = {20'h00000, pvid[p]};
				default: rd_mux = {17'h0, rate_eg[p], 1'b0, rate_in[p]};
			endcase
		end
	endfunction

	// look-up: VLAN, static, dynamic; all from one descriptor cycle
	logic vlan_on;
	logic [11:0] vid_eff;
	sfp_vlan_t ve;
	logic v_ok;
	logic [6:0] filter_group_id;
	logic [4:0] memb;
	logic s_ok;
	logic [4:0] s_ports;
	logic d_hit;
	logic [2:0] d_port;
	logic sa_hit;
	logic [$clog2(DT_N)-1:0] sa_idx;
	assign vlan_on = gctl3[`SFP_B_VLAN];
	assign vid_eff = (vlan_on && (!fd_tagged || fd_vid == 12'h000))
		? pvid[fd_port] : fd_vid;
	assign ve = vtab[vid_eff[6:0]];
	assign v_ok = !vlan_on || (ve[`SFP_VT_VALID]
		&& ve[`SFP_VT_VID] == vid_eff);
	assign filter_group_id = vlan_on ? ve[`SFP_VT_FID] : 7'h00;
	assign memb = vlan_on ? ve[`SFP_VT_MEMB] : 5'h1F;

	always_comb begin
		s_ok = 1'b0;
		s_ports = 5'h00;
		d_hit = 1'b0;
		d_port = 3'd0;
		sa_hit = 1'b0;
		sa_idx = '0;
		for (int i = 0; i < ST_N; i++) begin
			if (stab[i][`SFP_ST_VALID] && stab[i][`SFP_ST_MAC] == fd_da
				&& (!stab[i][`SFP_ST_USEG]
				|| stab[i][`SFP_ST_FID] == filter_group_id)) begin
				s_ok = 1'b1;
				s_ports = stab[i][`SFP_ST_PORTS];
			end
		end
		for (int i = 0; i < DT_N; i++) begin
			if (dtab[i][`SFP_DT_VALID] && dtab[i][`SFP_DT_FID] == filter_group_id) begin
				if (dtab[i][`SFP_DT_MAC] == fd_da) begin
					d_hit = 1'b1;
					d_port = dtab[i][`SFP_DT_PORT];
				end
				if (dtab[i][`SFP_DT_MAC] == fd_sa) begin
					sa_hit = 1'b1;
					sa_idx = ($clog2(DT_N))'(i);
				end
			end
		end
	end

	// snooping classifiers
	logic from_host;
	logic igmp;
	logic mld;
	logic trap;
	assign from_host = fd_port == `SFP_HOST;
	assign igmp = gctl3[`SFP_B_IGMP] && fd_is_ip && fd_ip_ver == `SFP_IP_V4
		&& fd_ip_proto == `SFP_PROTO_IGMP;
	assign mld = mld_on && fd_ip6_mcast && fd_hop_limit == 8'h01
		&& (nh_match(fd_next_hdr) || (fd_next_hdr == `SFP_NH_HBH
		&& nh_match(fd_hbh_next)));
	assign trap = (igmp || mld) && !from_host;

	function automatic logic nh_match(input logic [7:0] nh);
		nh_match = nh == `SFP_NH_ICMP || nh == `SFP_NH_ICMP6
			|| (mld_ext && (nh == 8'd43 || nh == 8'd44 || nh == 8'd50
			|| nh == 8'd51 || nh == 8'd60));
	endfunction

	// rate limits: byte buckets refilled every tick
	logic [4:0] in_open;
	logic [4:0] eg_open;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tick_cnt <= '0;
			tick <= 1'b0;
		end else begin
			tick <= tick_cnt == TW'(TICK_CYC - 1);
			tick_cnt <= (tick_cnt == TW'(TICK_CYC - 1)) ? '0 : tick_cnt + 1'b1;
		end
	end

	// kbps of a code; zero means no limit
	function automatic logic [19:0] rate_kbps(input sfp_rate_t c,
		input logic gig, input logic sp10);
		logic [19:0] r;
		r = 20'd0;
		if (c >= 7'd1 && c <= 7'd100)
			r = gig ? 20'(c) * 20'd10000 : 20'(c) * 20'd1000;
		else if (c > 7'd100)
			r = gig ? 20'(c - 7'd100) * 20'd640
				: 20'(c - 7'd100) * 20'd64;
		if (sp10 && r > 20'd10000)
			r = 20'd0;
		rate_kbps = r;
	endfunction

	logic [4:0] out_ports;
	logic drop;
	genvar g;
	generate
		for (g = 0; g < 5; g++) begin : g_rate
			logic [19:0] ri;
			logic [19:0] re;
			assign ri = rate_kbps(rate_in[g], pctl1[g][`SFP_B_GIG],
				pctl1[g][`SFP_B_SPEED10]);
			assign re = rate_kbps(rate_eg[g], pctl1[g][`SFP_B_GIG],
				pctl1[g][`SFP_B_SPEED10]);
			assign in_open[g] = ri == 20'd0 || bkt_in[g] != 24'd0;
			assign eg_open[g] = re == 20'd0 || bkt_eg[g] != 24'd0;
			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					bkt_in[g] <= 24'(BKT_MAX);
					bkt_eg[g] <= 24'(BKT_MAX);
				end else begin
					bkt_in[g] <= bkt_step(bkt_in[g], ri, tick,
						fd_valid && !drop && fd_port == 3'(g));
					bkt_eg[g] <= bkt_step(bkt_eg[g], re, tick,
						fd_valid && !drop && out_ports[g]);
				end
			end
		end
	endgenerate

	// credit added is kbps/8 bytes per millisecond; frames overdraw to zero
	function automatic logic [23:0] bkt_step(input logic [23:0] b,
		input logic [19:0] r, input logic t, input logic use_it);
		logic [24:0] v;
		v = {1'b0, b};
		if (t) v = v + 25'(r[19:3]);
		if (v > 25'(BKT_MAX)) v = 25'(BKT_MAX);
		if (use_it) v = (v > 25'(fd_len)) ? v - 25'(fd_len) : 25'd0;
		bkt_step = v[23:0];
	endfunction

	// destination selection, filtering and mirroring
	logic [4:0] fwd;
	logic [4:0] rx_sn;
	logic [4:0] tx_sn;
	logic [4:0] sniffer;
	logic mir;
	always_comb begin
		for (int p = 0; p < 5; p++) begin
			rx_sn[p] = pctl1[p][`SFP_B_RX_SNIFF];
			tx_sn[p] = pctl1[p][`SFP_B_TX_SNIFF];
			sniffer[p] = pctl1[p][`SFP_B_SNIFFER];
		end
		if (s_ok) fwd = s_ports;
		else if (d_hit) fwd = 5'(5'h01 << d_port);
		else fwd = memb;
		if (from_host && tail_on && !fd_tail_tag[7])
			fwd = {1'b0, fd_tail_tag[3:0]};
		if (trap) fwd = 5'h10;
		fwd = fwd & ~(5'(5'h01 << fd_port)) & eg_open;
		drop = !v_ok || fd_err || !in_open[fd_port];
		if (vlan_on && pctl2[fd_port][1] && !memb[fd_port])
			drop = 1'b1;
		if (pctl2[fd_port][0] && vid_eff != pvid[fd_port])
			drop = 1'b1;
		if (gctl3[`SFP_B_AND_MIRROR])
			mir = rx_sn[fd_port] && |(fwd & tx_sn);
		else
			mir = rx_sn[fd_port] || |(fwd & tx_sn);
		if (drop) begin
			fwd = 5'h00;
			// errored frames still reach the sniffer when asked
			mir = fd_err && v_ok && rx_sn[fd_port]
				&& pctl1[fd_port][`SFP_B_MIR_BAD];
		end
		// or-ing the sniffer mask gives a single copy
		out_ports = mir ? (fwd | sniffer) : fwd;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			dec_valid <= 1'b0;
			dec_ports <= 5'h00;
			dec_drop <= 1'b0;
			dec_trap <= 1'b0;
			dec_tail_tag <= 8'h00;
		end else begin
			dec_valid <= fd_valid;
			dec_ports <= fd_valid ? out_ports : 5'h00;
			dec_drop <= fd_valid && out_ports == 5'h00;
			dec_trap <= fd_valid && trap && out_ports[4];
			dec_tail_tag <= (fd_valid && tail_on && out_ports[4])
				? {6'h00, fd_port[1:0]} : 8'h00;
		end
	end

	// source learning; a valid VID is required, replacement is round robin
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int i = 0; i < DT_N; i++) dtab[i] <= '0;
			dt_ptr <= '0;
			age <= 4'h0;
			learn_cnt <= 16'h0000;
			drop_cnt <= 16'h0000;
		end else begin
			if (tick) age <= age + 4'h1;
			if (fd_valid && out_ports == 5'h00)
				drop_cnt <= drop_cnt + 16'h0001;
			if (fd_valid && !drop) begin
				if (sa_hit) begin
					dtab[sa_idx][`SFP_DT_STAMP] <= age;
				end else begin
					dtab[dt_ptr] <= {age, 1'b1, fd_port, 1'b0, filter_group_id,
						fd_sa};
					dt_ptr <= dt_ptr + 1'b1;
					learn_cnt <= learn_cnt + 16'h0001;
				end
			end
		end
	end

endmodule

// ===== testbench/sfp_chk.sv
// port checker for the forwarding policy block
module sfp_chk (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// register bus handshakes
	input wire logic s_axi_awvalid,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	// descriptor and decision
	input wire logic fd_valid,
	input wire logic [2:0] fd_port,
	input wire logic dec_valid,
	input wire logic [4:0] dec_ports,
	input wire logic dec_drop,
	input wire logic dec_trap,
	input wire logic [7:0] dec_tail_tag
);
	default clocking @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	// no back-pressure, so a lost decision shows up here first
	AST_DEC_NEXT: assert property (fd_valid |=> dec_valid)
		else $error("decision missing after descriptor");
	AST_DEC_CAUSE: assert property (dec_valid |-> $past(fd_valid))
		else $error("decision without descriptor");
	AST_DEC_IDLE: assert property (
		!dec_valid |-> dec_ports == 5'h00 && !dec_trap && !dec_drop)
		else $error("decision fields set while idle");
	AST_DROP: assert property (
		dec_valid |-> dec_drop == (dec_ports == 5'h00))
		else $error("drop flag disagrees with port mask");
	AST_TRAP: assert property (
		dec_trap |-> dec_ports[4] && $past(fd_port) != 3'd4)
		else $error("trapped frame not sent to host");
	AST_TAG_SRC: assert property (
		dec_tail_tag != 8'h00 |->
		dec_ports[4] && dec_tail_tag == {5'h00, $past(fd_port)})
		else $error("tail tag source wrong");
	AST_W_ANS: assert property (s_axi_awready |=> s_axi_bvalid)
		else $error("write response late");
	AST_R_ANS: assert property (s_axi_arready |=> s_axi_rvalid)
		else $error("read data late");
	AST_AW_TAKE: assert property (
		s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid |->
		##[0:2] s_axi_awready)
		else $error("write not taken");
	AST_AW_PULSE: assert property (s_axi_awready |=> !s_axi_awready)
		else $error("write ready held");
endmodule

bind sfp_top sfp_chk sfp_chk_i (.*);

// ===== testbench/sfp_port_src.sv
// frame source standing in for the switch port parsers
module sfp_port_src (
	// clock
	input wire logic aclk,
	// request from the bench
	input wire logic go,
	input wire logic [2:0] port,
	input wire logic [1:0] kind,
	input wire logic [47:0] da,
	input wire logic [7:0] nh,
	input wire logic [7:0] hbh,
	input wire logic [7:0] tag,
	// descriptor toward the block
	output logic fd_valid,
	output logic [2:0] fd_port,
	output logic fd_err,
	output logic [15:0] fd_len,
	output logic [47:0] fd_da,
	output logic [47:0] fd_sa,
	output logic fd_tagged,
	output logic [11:0] fd_vid,
	output logic fd_is_ip,
	output logic [3:0] fd_ip_ver,
	output logic [7:0] fd_ip_proto,
	output logic fd_ip6_mcast,
	output logic [7:0] fd_hop_limit,
	output logic [7:0] fd_next_hdr,
	output logic [7:0] fd_hbh_next,
	output logic [7:0] fd_tail_tag
);
	// idle fields wander every cycle so stale values never pass as data
	logic [47:0] junk = 48'hA5C3_5A3C_96E1;
	always_ff @(posedge aclk) begin
		junk <= {junk[46:0], ~junk[47]};
	end
	assign fd_valid = go;
	// igmp is version 4 protocol 2, listener frames one hop
	// host frames carry the reply's egress choice
	assign {fd_port, fd_err, fd_len, fd_da, fd_sa, fd_tagged, fd_vid,
		fd_is_ip, fd_ip_ver, fd_ip_proto, fd_ip6_mcast, fd_hop_limit,
		fd_next_hdr, fd_hbh_next, fd_tail_tag} = go ? {port, kind == 2'd3,
		16'h0040, da, 48'h0200_0000_0000 | 48'(port), 1'b0, 12'h000,
		kind == 2'd1, 4'h4, 8'h02, kind == 2'd2, 8'h01, nh, hbh, tag}
		: 175'({4{junk}});
endmodule

// ===== testbench/test_switch_forwarding_policy.sv
// self-checking bench for the forwarding policy block
module test_switch_forwarding_policy;
	timeunit 1ns;
	timeprecision 100ps;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic fd_valid, fd_err, fd_tagged, fd_is_ip, fd_ip6_mcast;
	logic [2:0] fd_port;
	logic [15:0] fd_len;
	logic [47:0] fd_da, fd_sa;
	logic [11:0] fd_vid;
	logic [3:0] fd_ip_ver;
	logic [7:0] fd_ip_proto, fd_hop_limit, fd_next_hdr, fd_hbh_next;
	logic [7:0] fd_tail_tag, dec_tail_tag;
	logic dec_valid, dec_drop, dec_trap;
	logic [4:0] dec_ports;
	logic go = 1'b0;
	logic [2:0] port = 3'd0;
	logic [1:0] kind = 2'd0;
	logic [47:0] da = 48'h0;
	logic [7:0] nh = 8'h00, hbh = 8'h00, tag = 8'h00;
	logic tail = 1'b0;
	int bad_count = 0;
	int tests_run = 0;
	int drops = 0;

	always #25 aclk = ~aclk;

	// tiny buckets, and no refill tick falls inside the run: drained stay shut
	sfp_top #(.BKT_MAX(64)) sfp_top_i (.*);
	sfp_port_src sfp_port_src_i (.*);

	function automatic logic [47:0] sa(input int p);
		return 48'h0200_0000_0000 | 48'(p);
	endfunction
	function automatic logic [47:0] rnd();
		return {8'h0C, 8'($urandom), 32'($urandom)};
	endfunction
	function automatic logic [4:0] flood(input int p, input logic [4:0] m);
		return m & ~(5'h01 << p);
	endfunction
	function automatic logic mld_hit(input logic [7:0] x, input int e);
		return x inside {8'h01, 8'h3A} ||
			(e != 0 && x inside {8'h2B, 8'h2C, 8'h32, 8'h33, 8'h3C});
	endfunction
	function automatic logic [15:0] dec_exp(input int p,
		input logic [4:0] m, input logic t);
		return {1'b1, t, m == 5'h00, m, 6'h00,
			(tail && m[4]) ? 2'(p) : 2'd0};
	endfunction

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task automatic chk_dec(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (exp[13])
			drops++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] %0t decision %h exp %h", $time, got, exp);
		end
	endtask
	task automatic chk_reg(input logic [33:0] got, input logic [33:0] exp);
		tests_run++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] %0t register %h exp %h", $time, got, exp);
		end
	endtask
	task automatic hang(input int n);
		if (n >= 40) begin
			bad_count++;
			wrap_up();
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
		end while (s_axi_awready !== 1'b1 && n < 40);
		s_axi_awvalid <= 1'b0;
		s_axi_wvalid <= 1'b0;
		while (s_axi_bvalid !== 1'b1 && n < 40) begin
			@(posedge aclk);
			n++;
		end
		s_axi_bready <= 1'b0;
		hang(n);
		@(posedge aclk);
	endtask
	task automatic rd(input logic [11:0] a, input logic [33:0] exp);
		int n;
		n = 0;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
		end while (s_axi_arready !== 1'b1 && n < 40);
		s_axi_arvalid <= 1'b0;
		while (s_axi_rvalid !== 1'b1 && n < 40) begin
			@(posedge aclk);
			n++;
		end
		s_axi_rready <= 1'b0;
		hang(n);
		chk_reg({s_axi_rresp, s_axi_rdata}, exp);
		@(posedge aclk);
	endtask
	// one descriptor, decision read at the edge one cycle after it
	task automatic frame(input int p, input logic [1:0] k,
		input logic [47:0] d, input logic [4:0] m, input logic t,
		input logic [7:0] n = 8'h11, input logic [7:0] h = 8'h11,
		input logic [7:0] g = 8'h80);
		port <= 3'(p);
		kind <= k;
		da <= d;
		nh <= n;
		hbh <= h;
		tag <= g;
		go <= 1'b1;
		@(posedge aclk);
		go <= 1'b0;
		@(posedge aclk);
		chk_dec({dec_valid, dec_trap, dec_drop, dec_ports, dec_tail_tag},
			dec_exp(p, m, t));
	endtask

	initial begin
		logic [7:0] hl [8];
		int p;
		hl = '{8'h01, 8'h3A, 8'h2B, 8'h2C, 8'h32, 8'h33, 8'h3C, 8'h11};
		void'($urandom(32'h7013));
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		rd(12'h308, {2'b00, 32'h1});
		rd(12'hFFC, {2'b10, 32'h0});
		wr(12'h014, 32'hC1);
		rd(12'h014, {2'b00, 32'hC1});
		wr(12'h014, 32'h0);
		frame(1, 0, rnd(), 5'h1D, 0);
		repeat (12) begin
			p = $urandom_range(3);
			frame(p, 0, rnd(), flood(p, 5'h1F), 0);
		end
		frame(2, 0, sa(1), 5'h02, 0);
		for (int e = 0; e < 2; e++) begin
			wr(12'h014, 32'(e) << 6);
			frame(2, 1, rnd(), e ? 5'h10 : 5'h1B, e != 0);
		end
		wr(12'h030, 32'h2);
		tail = 1'b1;
		for (int q = 0; q < 4; q++) frame(q, 1, rnd(), 5'h10, 1);
		frame(4, 0, rnd(), 5'h01, 0, 8'h11, 8'h11, 8'h41);
		frame(4, 0, rnd(), 5'h0F, 0, 8'h11, 8'h11, 8'h4F);
		wr(12'h014, 32'h0);
		frame(3, 2, rnd(), 5'h17, 0, 8'h3A);
		// hop-by-hop value must only count when next header is zero
		for (int e = 0; e < 2; e++) begin
			wr(12'h290, 32'h4 | (32'(e) << 3));
			foreach (hl[i]) begin
				frame(3, 2, rnd(), mld_hit(hl[i], e) ? 5'h10 : 5'h17,
					mld_hit(hl[i], e), hl[i], 8'h3A);
				frame(3, 2, rnd(), mld_hit(hl[i], e) ? 5'h10 : 5'h17,
					mld_hit(hl[i], e), 8'h00, hl[i]);
			end
		end
		wr(12'h290, 32'h0);
		wr(12'h300, 32'h1);
		wr(12'h330, 32'h4);
		frame(0, 0, sa(1), 5'h0A, 0);
		frame(0, 0, rnd(), 5'h1E, 0);
		wr(12'h320, 32'h2);
		frame(4, 0, sa(2), 5'h0C, 0);
		wr(12'h014, 32'h1);
		frame(0, 0, sa(1), 5'h02, 0);
		frame(0, 0, sa(2), 5'h0C, 0);
		wr(12'h014, 32'h0);
		frame(0, 3, sa(1), 5'h00, 0);
		wr(12'h300, 32'h9);
		frame(0, 3, sa(1), 5'h08, 0);
		wr(12'h300, 32'h0);
		wr(12'h320, 32'h0);
		wr(12'h330, 32'h0);
		wr(12'h014, 32'h80);
		frame(0, 0, rnd(), 5'h00, 0);
		wr(12'h2D0, 32'h0000_3385);
		wr(12'h2DC, 32'h0000_0001);
		frame(0, 0, sa(1), 5'h06, 0);
		frame(1, 0, rnd(), 5'h05, 0);
		frame(0, 0, sa(1), 5'h02, 0);
		wr(12'h2D0, 32'h0000_00C0);
		wr(12'h2D4, 32'h02E8_0A00);
		wr(12'h2DC, 32'h0000_0100);
		frame(0, 0, 48'h0A00_0000_00C0, 5'h08, 0);
		wr(12'h334, 32'h40);
		frame(3, 0, rnd(), 5'h00, 0);
		wr(12'h014, 32'h0);
		frame(0, 0, 48'h0A00_0000_00C0, 5'h1E, 0);
		wr(12'h31C, 32'h01);
		frame(1, 0, rnd(), 5'h00, 0);
		wr(12'h310, 32'h10);
		wr(12'h31C, 32'h0B);
		frame(1, 0, rnd(), 5'h1D, 0);
		wr(12'h31C, 32'h65);
		frame(1, 0, rnd(), 5'h00, 0);
		wr(12'h31C, 32'h0100);
		frame(2, 0, rnd(), 5'h19, 0);
		rd(12'h2E4, {2'b00, 32'(drops)});
		wrap_up();
	end
endmodule
